/* rtl/interval_timer_map.svh */
// Function
// - Registers are eight bits, byte access only.
// - Low control bits select interval flag source.
// - Bits 3-4 select frame clock from low counter.
// - Hold freezes high; low only with cascade.
// - Hold stops high counting and flag generation.
// - Source and cascade bits pick high counter clock.
// - Split mode low counter counts every auxiliary tick.
// - In cascade, low counter wrap clocks high counter.
// - Cascade forms one 16-bit auxiliary counter.
// - Both counters fully readable and writable.
// - Registers accessible regardless of hold.
// - Flag at bit 7, cleared on acceptance.
// - Enable bit 7, cleared on reset, gated globally.
`ifndef INTERVAL_TIMER_MAP_SVH
`define INTERVAL_TIMER_MAP_SVH

`define TIMER_CONTROL_OFFSET    8'h40
`define LOW_COUNTER_OFFSET      8'h46
`define HIGH_COUNTER_OFFSET     8'h47
`define IRQ_FLAG_REG_TWO_OFFSET 8'h48
`define IRQ_ENABLE_REG_TWO_OFFSET 8'h49

`define INTERVAL_CODE_LSB_POS   0
`define INTERVAL_CODE_MSB_POS   2
`define FRAME_SELECT_LO_POS     3
`define FRAME_SELECT_HI_POS     4
`define SOURCE_SELECT_POS       5
`define HOLD_POS                6
`define CASCADE_SELECT_POS      7
`define TIMER_IRQ_FLAG_POS      7
`define TIMER_IRQ_ENABLE_POS    7

`define FRAME_BASE_BIT          4
`define REG_RESET_VALUE         8'h00

`endif

/* rtl/interval_timer_pkg.sv */
package interval_timer_pkg;

  typedef enum logic [1:0] {
    SRC_AUX      = 2'h0,
    SRC_AUX_DIV  = 2'h1,
    SRC_MAIN     = 2'h2,
    SRC_AUX_DIV2 = 2'h3
  } high_source_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_t;

endpackage

/* rtl/event_sync.sv */
`timescale 1ns/1ps
// Carries a toggle-coded event into the processor clock domain.
module event_sync
  import interval_timer_pkg::*;
(
  // Clock and reset
  input  wire logic CLK,
  input  wire logic ARST_N,
  // Event toggle in, pulse out
  input  wire logic TOGGLE_IN,
  output logic      PULSE_OUT
);

  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= TOGGLE_IN;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign PULSE_OUT = sync_reg ^ last_reg;

endmodule

/* rtl/interval_timer.sv */
`timescale 1ns/1ps
`include "interval_timer_map.svh"
// Two cascadable 8-bit counters with interval flag and display frame clock.
// Auxiliary and main clocks arrive as enable inputs synchronous to CLK.
module interval_timer
  import interval_timer_pkg::*;
#(
  parameter int CNT_WIDTH = 8
) (
  // System
  input  wire logic       CLK,
  input  wire logic       ARST_N,
  // Wishbone slave
  input  wire logic       CYC_I,
  input  wire logic       STB_I,
  input  wire logic       WE_I,
  input  wire logic [7:0] ADR_I,
  input  wire logic [0:0] SEL_I,
  input  wire logic [7:0] DAT_I,
  output logic      [7:0] DAT_O,
  output logic            ACK_O,
  output logic            ERR_O,
  // Clock ticks
  input  wire logic       AUX_TICK,
  input  wire logic       MAIN_TICK,
  // Processor interrupt interface
  input  wire logic       GLOBAL_IRQ_ENABLE,
  input  wire logic       IRQ_ACCEPT,
  output logic            TIMER_IRQ,
  // Display
  output logic            DISPLAY_FRAME_CLOCK
);

  initial begin
    if (CNT_WIDTH != 8) $error("interval_timer supports only 8-bit counters");
  end

  logic [7:0] timer_control_reg;
  logic [7:0] low_counter_reg;
  logic [7:0] low_counter_next;
  logic [7:0] high_counter_reg;
  logic [7:0] high_counter_next;
  logic       timer_irq_flag_reg;
  logic       timer_irq_enable_reg;
  logic       frame_clock_reg;
  logic       low_msb_prev_reg;
  logic       sel_bit_prev_reg;
  logic       event_toggle_reg;
  logic [7:0] read_data_reg;
  bus_state_t bus_state_reg;

  // Register bus decode.
  function automatic logic addr_hit(input logic [7:0] adr, input logic [7:0] off);
    addr_hit = (adr == off);
  endfunction

  wire bus_req     = CYC_I && STB_I && (bus_state_reg == BUS_IDLE);
  wire byte_ok     = SEL_I[0];
  wire hit_ctl     = addr_hit(ADR_I, `TIMER_CONTROL_OFFSET);
  wire hit_low     = addr_hit(ADR_I, `LOW_COUNTER_OFFSET);
  wire hit_high    = addr_hit(ADR_I, `HIGH_COUNTER_OFFSET);
  wire hit_flag    = addr_hit(ADR_I, `IRQ_FLAG_REG_TWO_OFFSET);
  wire hit_en      = addr_hit(ADR_I, `IRQ_ENABLE_REG_TWO_OFFSET);
  wire hit_any     = hit_ctl | hit_low | hit_high | hit_flag | hit_en;
  wire wr_fire     = bus_req && WE_I && byte_ok && hit_any;
  wire wr_ctl      = wr_fire && hit_ctl;
  wire wr_low      = wr_fire && hit_low;
  wire wr_high     = wr_fire && hit_high;
  wire wr_flag     = wr_fire && hit_flag;
  wire wr_en       = wr_fire && hit_en;

  // Control fields.
  wire [2:0] interval_code = timer_control_reg[`INTERVAL_CODE_MSB_POS:`INTERVAL_CODE_LSB_POS];
  wire [1:0] frame_select  = {timer_control_reg[`FRAME_SELECT_HI_POS],
                              timer_control_reg[`FRAME_SELECT_LO_POS]};
  wire       hold          = timer_control_reg[`HOLD_POS];
  wire       cascade       = timer_control_reg[`CASCADE_SELECT_POS];
  wire [1:0] src_code      = {timer_control_reg[`SOURCE_SELECT_POS], cascade};
  high_source_t high_src;
  assign high_src = high_source_t'(src_code);

  // Low counter runs on every auxiliary tick unless held in cascade mode.
  wire low_hold  = hold && cascade;
  wire low_step  = AUX_TICK && !low_hold;
  wire low_wrap  = low_step && (low_counter_reg == 8'hff);
  // Falling edge of the low MSB marks a divide-by-256 tick.
  wire msb_fall  = low_msb_prev_reg && !low_counter_reg[7];

  logic high_tick;
  always_comb begin
    case (high_src)
      SRC_AUX:      high_tick = AUX_TICK;
      SRC_AUX_DIV:  high_tick = cascade ? low_wrap : msb_fall;
      SRC_MAIN:     high_tick = MAIN_TICK;
      SRC_AUX_DIV2: high_tick = cascade ? low_wrap : msb_fall;
      default:      high_tick = 1'b0;
    endcase
  end
  wire high_step = high_tick && !hold;

  assign low_counter_next  = wr_low ? DAT_I :
                             low_step ? low_counter_reg + 8'h01 : low_counter_reg;
  assign high_counter_next = wr_high ? DAT_I :
                             high_step ? high_counter_reg + 8'h01 : high_counter_reg;

  // Interval source bit and rising edge detection.
  wire sel_bit   = high_counter_reg[interval_code];
  wire sel_rise  = sel_bit && !sel_bit_prev_reg && !hold;

  // Frame clock: bit 4 is divide by 32, up to bit 7 for divide by 256.
  wire [2:0] frame_bit_idx = 3'(`FRAME_BASE_BIT) + {1'b0, frame_select};
  wire       frame_src     = low_counter_reg[frame_bit_idx];

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      timer_control_reg <= `REG_RESET_VALUE;
      low_counter_reg   <= `REG_RESET_VALUE;
      high_counter_reg  <= `REG_RESET_VALUE;
      low_msb_prev_reg  <= 1'b0;
      sel_bit_prev_reg  <= 1'b0;
      frame_clock_reg   <= 1'b0;
    end else begin
      if (wr_ctl) begin
        timer_control_reg <= DAT_I;
      end
      low_counter_reg  <= low_counter_next;
      high_counter_reg <= high_counter_next;
      low_msb_prev_reg <= low_counter_reg[7];
      sel_bit_prev_reg <= sel_bit;
      if (!hold) begin
        frame_clock_reg <= frame_src;
      end
    end
  end

  // Flag event leaves the counter logic as a toggle.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      event_toggle_reg <= 1'b0;
    end else if (sel_rise) begin
      event_toggle_reg <= ~event_toggle_reg;
    end
  end

  logic flag_set;
  event_sync u_event_sync (
    .CLK       (CLK),
    .ARST_N    (ARST_N),
    .TOGGLE_IN (event_toggle_reg),
    .PULSE_OUT (flag_set)
  );

  // Set wins over any clear in the same cycle.
  wire flag_clear = IRQ_ACCEPT || (wr_flag && !DAT_I[`TIMER_IRQ_FLAG_POS]);
  wire flag_swset = wr_flag && DAT_I[`TIMER_IRQ_FLAG_POS];

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      timer_irq_flag_reg   <= 1'b0;
      timer_irq_enable_reg <= 1'b0;
    end else begin
      if (flag_set || flag_swset) begin
        timer_irq_flag_reg <= 1'b1;
      end else if (flag_clear) begin
        timer_irq_flag_reg <= 1'b0;
      end
      if (wr_en) begin
        timer_irq_enable_reg <= DAT_I[`TIMER_IRQ_ENABLE_POS];
      end
    end
  end

  assign TIMER_IRQ = timer_irq_flag_reg && timer_irq_enable_reg && GLOBAL_IRQ_ENABLE;
  assign DISPLAY_FRAME_CLOCK = frame_clock_reg;

  // Read mux.
  wire [7:0] rd_mux = hit_ctl  ? timer_control_reg :
                      hit_low  ? low_counter_reg :
                      hit_high ? high_counter_reg :
                      hit_flag ? {timer_irq_flag_reg, 7'h00} :
                      hit_en   ? {timer_irq_enable_reg, 7'h00} : 8'h00;

  // One-cycle answer; unmapped or no byte lane gives ERR.
  logic ack_reg;
  logic err_reg;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bus_state_reg <= BUS_IDLE;
      ack_reg       <= 1'b0;
      err_reg       <= 1'b0;
      read_data_reg <= 8'h00;
    end else begin
      case (bus_state_reg)
        BUS_IDLE: begin
          if (bus_req) begin
            bus_state_reg <= BUS_ACK;
            ack_reg       <= hit_any && byte_ok;
            err_reg       <= !(hit_any && byte_ok);
            read_data_reg <= rd_mux;
          end
        end
        BUS_ACK: begin
          bus_state_reg <= BUS_IDLE;
          ack_reg       <= 1'b0;
          err_reg       <= 1'b0;
        end
        default: begin
          bus_state_reg <= BUS_IDLE;
          ack_reg       <= 1'b0;
          err_reg       <= 1'b0;
        end
      endcase
    end
  end

  assign ACK_O = ack_reg;
  assign ERR_O = err_reg;
  assign DAT_O = read_data_reg;

endmodule

/* test/interval_timer_props.sv */
`timescale 1ns/1ps
module interval_timer_props (
  // Observed ports
  input wire logic       CLK,
  input wire logic       ARST_N,
  input wire logic       CYC_I,
  input wire logic       STB_I,
  input wire logic [0:0] SEL_I,
  input wire logic       ACK_O,
  input wire logic       ERR_O,
  input wire logic       AUX_TICK,
  input wire logic       GLOBAL_IRQ_ENABLE,
  input wire logic       TIMER_IRQ,
  input wire logic       DISPLAY_FRAME_CLOCK
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);
  a_ack_one_pulse: assert property (ACK_O |=> !ACK_O)
    else $error("ack held too long");
  a_ack_has_req: assert property ((ACK_O || ERR_O) |-> $past(CYC_I && STB_I))
    else $error("answer without request");
  a_idle_no_ans: assert property (!(CYC_I && STB_I) |=> !(ACK_O || ERR_O))
    else $error("answer while idle");
  a_ans_next: assert property (CYC_I && STB_I && !ACK_O && !ERR_O |=> ACK_O || ERR_O)
    else $error("request not answered");
  a_sel_refused: assert property (CYC_I && STB_I && !SEL_I[0] && !ACK_O && !ERR_O
    |=> ERR_O && !ACK_O)
    else $error("bad lane accepted");
  a_ans_exclusive: assert property (!(ACK_O && ERR_O))
    else $error("ack and err together");
  a_irq_gated: assert property (TIMER_IRQ |-> GLOBAL_IRQ_ENABLE)
    else $error("irq without global enable");
  a_frame_cause: assert property ($changed(DISPLAY_FRAME_CLOCK) |-> $past(AUX_TICK, 2) || $past(ACK_O))
    else $error("frame clock moved without cause");
endmodule
bind interval_timer interval_timer_props props (.CLK, .ARST_N, .CYC_I, .STB_I, .SEL_I, .ACK_O,
  .ERR_O, .AUX_TICK, .GLOBAL_IRQ_ENABLE, .TIMER_IRQ, .DISPLAY_FRAME_CLOCK);

/* test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic       CLK, ARST_N, CYC_I, STB_I, WE_I, AUX_TICK, MAIN_TICK, ACK_O, ERR_O;
  logic       GLOBAL_IRQ_ENABLE, IRQ_ACCEPT, TIMER_IRQ, DISPLAY_FRAME_CLOCK;
  logic [7:0] ADR_I, DAT_I, DAT_O;
  logic [0:0] SEL_I;
  int         mismatches, n_checks;
  interval_timer dut (.CLK, .ARST_N, .CYC_I, .STB_I, .WE_I, .ADR_I, .SEL_I, .DAT_I, .DAT_O,
    .ACK_O, .ERR_O, .AUX_TICK, .MAIN_TICK, .GLOBAL_IRQ_ENABLE, .IRQ_ACCEPT, .TIMER_IRQ,
    .DISPLAY_FRAME_CLOCK);
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  // Classic Wishbone cycle; entered right after a rising edge.
  task automatic bus(input logic we, input logic [7:0] a, d, input logic s,
                     output logic [7:0] q, output logic e);
    int n;
    n = 0;
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I  <= we;
    ADR_I <= a;
    DAT_I <= d;
    SEL_I <= s;
    do begin
      @(posedge CLK);
      n++;
    end while (ACK_O !== 1'b1 && ERR_O !== 1'b1 && n < 20);
    q = DAT_O;
    e = ERR_O;
    if (n >= 20) mismatches++;
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [7:0] q;
    logic       e;
    bus(1'b1, a, d, 1'b1, q, e);
  endtask
  task automatic rd(input logic [7:0] a, exp);
    logic [7:0] q;
    logic       e;
    bus(1'b0, a, 8'h00, 1'b1, q, e);
    chk("read data", exp, q);
  endtask
  task automatic tk(input logic a, m, input int n);
    repeat (n) begin
      AUX_TICK  <= a;
      MAIN_TICK <= m;
      @(posedge CLK);
      AUX_TICK  <= 1'b0;
      MAIN_TICK <= 1'b0;
      @(posedge CLK);
    end
  endtask
  task automatic pins(input logic [1:0] exp);
    @(negedge CLK);
    chk("irq,frame", {6'h00, exp}, {6'h00, TIMER_IRQ, DISPLAY_FRAME_CLOCK});
    @(posedge CLK);
  endtask
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  initial begin
    repeat (20000) @(posedge CLK);
    mismatches++;
    summarize();
  end
  initial begin
    logic [7:0] q;
    logic       e;
    {ARST_N, CYC_I, STB_I, WE_I, AUX_TICK, MAIN_TICK, IRQ_ACCEPT} = 7'h00;
    {ADR_I, DAT_I, SEL_I, GLOBAL_IRQ_ENABLE} = 18'h00001;
    mismatches = 0;
    n_checks = 0;
    repeat (20) @(posedge CLK);
    ARST_N <= 1'b1;
    @(posedge CLK);
    rd(8'h49, 8'h00);
    wr(8'h40, 8'h58);
    wr(8'h46, 8'ha5);
    wr(8'h47, 8'h3c);
    rd(8'h40, 8'h58);
    tk(1'b1, 1'b1, 3);
    rd(8'h46, 8'ha8);
    rd(8'h47, 8'h3c);
    $display("test hold done");
    for (int i = 0; i < 2; i++) begin
      wr(8'h40, i ? 8'ha0 : 8'h80);
      wr(8'h46, 8'hff);
      wr(8'h47, 8'h20);
      tk(1'b1, 1'b0, 1);
      rd(8'h46, 8'h00);
      rd(8'h47, 8'h21);
    end
    wr(8'h40, 8'hc0);
    tk(1'b1, 1'b1, 2);
    rd(8'h46, 8'h00);
    rd(8'h47, 8'h21);
    $display("test cascade done");
    wr(8'h40, 8'h00);
    wr(8'h46, 8'h10);
    wr(8'h47, 8'hf0);
    tk(1'b1, 1'b0, 5);
    rd(8'h46, 8'h15);
    rd(8'h46, 8'h15);
    rd(8'h47, 8'hf5);
    wr(8'h40, 8'h20);
    wr(8'h46, 8'h00);
    wr(8'h47, 8'h00);
    tk(1'b0, 1'b1, 4);
    tk(1'b1, 1'b0, 2);
    rd(8'h46, 8'h02);
    rd(8'h47, 8'h04);
    $display("test sources done");
    for (int k = 0; k < 4; k++) begin
      wr(8'h40, 8'(k << 3));
      wr(8'h46, 8'((16 << k) - 1));
      pins(2'b00);
      tk(1'b1, 1'b0, 1);
      pins(2'b01);
    end
    $display("test frame done");
    wr(8'h40, 8'h02);
    wr(8'h47, 8'h03);
    wr(8'h48, 8'h00);
    wr(8'h49, 8'h80);
    pins(2'b00);
    tk(1'b1, 1'b0, 1);
    repeat (3) @(posedge CLK);
    pins(2'b10);
    rd(8'h48, 8'h80);
    GLOBAL_IRQ_ENABLE <= 1'b0;
    pins(2'b00);
    GLOBAL_IRQ_ENABLE <= 1'b1;
    pins(2'b10);
    IRQ_ACCEPT <= 1'b1;
    @(posedge CLK);
    IRQ_ACCEPT <= 1'b0;
    pins(2'b00);
    rd(8'h48, 8'h00);
    $display("test irq done");
    bus(1'b0, 8'h41, 8'h00, 1'b1, q, e);
    chk("unmapped err", 8'h01, {7'h00, e});
    bus(1'b1, 8'h40, 8'h77, 1'b0, q, e);
    chk("lane err", 8'h01, {7'h00, e});
    rd(8'h40, 8'h02);
    $display("test refuse done");
    summarize();
  end
endmodule
